// ### shared/suspend_cmd_pkg.sv
// constants for the host-side erase-suspend command sequencer
package suspend_cmd_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;
  localparam logic [11:0] ADDR_ANY     = 12'h000;
  localparam logic [7:0] CMD_RESET      = 8'hF0;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_STAT_CLR   = 8'h71;
  localparam logic [7:0] CMD_UNLOCK1    = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2    = 8'h55;
  localparam logic [7:0] CMD_EXIT_ENTRY = 8'h90;
  localparam logic [7:0] CMD_EXIT       = 8'h00;
  localparam logic [7:0] CMD_BIT_WRITE  = 8'hA0;
  localparam logic [7:0] CMD_WORD_CNT   = 8'h03;
  localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0] CMD_PG_SUSPEND = 8'h51;
  localparam logic [7:0] CMD_RESUME     = 8'h30;
  localparam logic [7:0] CMD_PG_RESUME  = 8'h50;
  localparam int READY_BIT = 7;
  localparam int MAX_WORDS = 256;
  // erase-suspend latency, figure in us, waited only after a reset command
  localparam int CLK_MHZ            = 40;
  localparam int SUSPEND_LATENCY_US = 45;
  localparam int LATENCY_CYC        = SUSPEND_LATENCY_US * CLK_MHZ;
  // host operations
  typedef enum logic [2:0] {
    OP_PROT_SET   = 3'h0,
    OP_PROT_EXIT  = 3'h1,
    OP_SUSPEND    = 3'h2,
    OP_RESUME     = 3'h3,
    OP_STATUS     = 3'h4,
    OP_RESET      = 3'h5,
    OP_STAT_CLR   = 3'h6,
    OP_UNLOCK_RES = 3'h7
  } op_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WRITE = 3'b001,
    ST_GAP   = 3'b011,
    ST_READ  = 3'b010,
    ST_WAIT  = 3'b110,
    ST_DONE  = 3'b111
  } state_e;
endpackage

// ### verilog/suspend_cmd_host.sv
// host sequencer issuing erase-suspend sub-mode command cycles to the flash
`timescale 1ns/1ps
module suspend_cmd_host (
  input  wire logic                               mclk,
  input  wire logic                               resetn,
  input  wire logic                               opValid,
  input  wire suspend_cmd_pkg::op_e               opCode,
  input  wire logic [suspend_cmd_pkg::DATA_W-1:0] opArg,
  output logic                                    opReady,
  output logic                                    opDone,
  output logic [suspend_cmd_pkg::DATA_W-1:0]      statusOut,
  output logic [suspend_cmd_pkg::ADDR_W-1:0]      flashAddr,
  output logic [suspend_cmd_pkg::DATA_W-1:0]      flashDout,
  output logic                                    flashDoe,
  output logic                                    flashWeN,
  output logic                                    flashOeN,
  input  wire logic [suspend_cmd_pkg::DATA_W-1:0] flashDin
);
  import suspend_cmd_pkg::*;

  // sequencer state and the held request
  state_e                  state_q, state_d;
  logic [1:0]              step_q, step_d;
  logic [1:0]              last_q, last_d;
  op_e                     op_q, op_d;
  logic [DATA_W-1:0]       arg_q, arg_d;
  // latency countdown; the wait in cycles fits in twelve bits
  logic [11:0]             wait_q, wait_d;
  logic                    readAfter_q, readAfter_d;
  // registered pin and handshake drive
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [DATA_W-1:0]       dout_q, dout_d;
  logic                    doe_q, doe_d;
  logic                    weN_q, weN_d;
  logic                    oeN_q, oeN_d;
  logic                    rdy_q, rdy_d;
  logic                    done_q, done_d;
  logic [DATA_W-1:0]       stat_q, stat_d;
  // cycle decode for the current write
  logic [ADDR_W-1:0]       cycAddr;
  logic [DATA_W-1:0]       cycData;

  // address and data of write cycle number step for the held operation
  always_comb begin
    // writes that need no unlock address go to offset zero
    cycAddr = ADDR_ANY;
    cycData = CMD_RESET;
    unique case (op_q)
      OP_PROT_SET: cycData = CMD_BIT_WRITE;
      OP_PROT_EXIT: cycData = (step_q == 2'd0) ? CMD_EXIT_ENTRY : CMD_EXIT;
      OP_SUSPEND: cycData = arg_q[0] ? CMD_PG_SUSPEND : CMD_SUSPEND;
      OP_RESUME: cycData = arg_q[0] ? CMD_PG_RESUME : CMD_RESUME;
      OP_STATUS: begin
        cycAddr = ADDR_UNLOCK1;
        cycData = CMD_STATUS;
      end
      OP_RESET: cycData = CMD_RESET;
      OP_STAT_CLR: begin
        cycAddr = ADDR_UNLOCK1;
        cycData = CMD_STAT_CLR;
      end
      OP_UNLOCK_RES: begin
        if (step_q == 2'd0) begin
          cycAddr = ADDR_UNLOCK1;
          cycData = CMD_UNLOCK1;
        end else if (step_q == 2'd1) begin
          cycAddr = ADDR_UNLOCK2;
          cycData = CMD_UNLOCK2;
        end else begin
          // third write is the resume itself
          cycData = arg_q[0] ? CMD_PG_RESUME : CMD_RESUME;
        end
      end
    endcase
  end

  // sequencer next state; each write is one cycle of we low, one gap cycle
  always_comb begin
    state_d     = state_q;
    step_d      = step_q;
    last_d      = last_q;
    op_d        = op_q;
    arg_d       = arg_q;
    wait_d      = wait_q;
    readAfter_d = readAfter_q;
    addr_d      = addr_q;
    dout_d      = dout_q;
    doe_d       = 1'b0;
    weN_d       = 1'b1;
    oeN_d       = 1'b1;
    rdy_d       = 1'b0;
    done_d      = 1'b0;
    stat_d      = stat_q;

    // strobes default inactive, so every state not driving them releases them
    unique case (state_q)
      // idle: offer ready and latch the request on the taking edge
      ST_IDLE: begin
        // buffered loads are never issued, so count and sector checks stay with the device
        rdy_d = 1'b1;
        if (opValid && rdy_q) begin
          // request taken; ready drops at once so nothing is queued
          rdy_d       = 1'b0;
          op_d        = opCode;
          arg_d       = opArg;
          step_d      = 2'd0;
          last_d      = (opCode == OP_UNLOCK_RES) ? 2'd2 :
                        (opCode == OP_PROT_EXIT) ? 2'd1 : 2'd0;
          readAfter_d = (opCode == OP_STATUS) || (opCode == OP_SUSPEND);
          state_d     = ST_WRITE;
        end
      end
      // one cycle of write strobe with the data driven
      ST_WRITE: begin
        // address and data come from the cycle decode above
        addr_d  = cycAddr;
        dout_d  = cycData;
        doe_d   = 1'b1;
        weN_d   = 1'b0;
        state_d = ST_GAP;
      end
      // gap cycle: next write, a read, or wind-up
      ST_GAP: begin
        if (step_q != last_q) begin
          // more writes of a multi-write sequence
          step_d  = step_q + 2'd1;
          state_d = ST_WRITE;
        end else if (readAfter_q) begin
          // data bus is released on the same edge as the read strobe falls
          oeN_d   = 1'b0;
          state_d = ST_READ;
        end else begin
          // after a reset command, wait out the latency before done; other writes finish now
          wait_d  = LATENCY_CYC[11:0];
          state_d = (op_q == OP_RESET) ? ST_WAIT : ST_DONE;
        end
      end
      ST_READ: begin
        // poll status until ready while suspend is pending
        stat_d = flashDin;
        if (op_q == OP_SUSPEND && !flashDin[READY_BIT]) begin
          // still busy: keep the read strobe low and sample again
          oeN_d   = 1'b0;
          state_d = ST_READ;
        end else begin
          // single status read, or the poll has seen ready
          state_d = ST_DONE;
        end
      end
      // count the latency down to zero inclusive
      ST_WAIT: begin
        wait_d = wait_q - 12'd1;
        if (wait_q == 12'd0) begin
          state_d = ST_DONE;
        end
      end
      // one-cycle done pulse; ready returns a cycle later
      ST_DONE: begin
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      // unused codes fall back to idle
      default: state_d = ST_IDLE;
    endcase
  end

  // registers; all outputs come from these flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // idle levels: strobes high, data bus released
      state_q     <= ST_IDLE;
      step_q      <= 2'd0;
      last_q      <= 2'd0;
      op_q        <= OP_RESET;
      arg_q       <= 8'h00;
      wait_q      <= 12'h000;
      readAfter_q <= 1'b0;
      addr_q      <= 12'h000;
      dout_q      <= 8'h00;
      doe_q       <= 1'b0;
      weN_q       <= 1'b1;
      oeN_q       <= 1'b1;
      rdy_q       <= 1'b0;
      done_q      <= 1'b0;
      stat_q      <= 8'h00;
    end else begin
      // every register follows its next value
      state_q     <= state_d;
      step_q      <= step_d;
      last_q      <= last_d;
      op_q        <= op_d;
      arg_q       <= arg_d;
      wait_q      <= wait_d;
      readAfter_q <= readAfter_d;
      addr_q      <= addr_d;
      dout_q      <= dout_d;
      doe_q       <= doe_d;
      weN_q       <= weN_d;
      oeN_q       <= oeN_d;
      rdy_q       <= rdy_d;
      done_q      <= done_d;
      stat_q      <= stat_d;
    end
  end

  // request handshake and status
  assign opReady   = rdy_q;
  assign opDone    = done_q;
  assign statusOut = stat_q;

  // flash pin drive
  assign flashAddr = addr_q;
  assign flashDout = dout_q;
  assign flashDoe  = doe_q;
  assign flashWeN  = weN_q;
  assign flashOeN  = oeN_q;
endmodule

// ### sim/flash_model.sv
// behavioural flash device for the erase-suspend sub-modes
`timescale 1ns/1ps
module flash_model (
  input  wire logic        mclk,
  input  wire logic [11:0] flashAddr,
  input  wire logic [7:0]  flashDout,
  input  wire logic        flashWeN,
  input  wire logic        flashOeN,
  input  wire logic        preset,
  input  wire logic [3:0]  presetState,
  output logic      [7:0]  flashDin,
  output logic      [3:0]  devState
);
  localparam logic [7:0] PROG_CYC = 8'hC7;
  logic [1:0] polls = 2'h0;
  logic [7:0] busyCnt = 8'h00;
  logic [7:0] lastQ = 8'h00;
  logic       ready;
  logic [7:0] d;
  assign d = flashDout;
  // busy while programming; a pending suspend reads busy twice, ready on the third poll, the slow case
  assign ready = (devState == 4'h5) ? (polls == 2'h2) : (devState != 4'h4);
  // released bus shows the inverse of the last read, not a stale value
  assign flashDin = flashOeN ? ~lastQ : {ready, 7'h00};
  // state moves on write strobes; a read moves it only on the ready poll of a pending suspend
  always @(posedge mclk) begin
    // programming left alone finishes and the device goes idle
    busyCnt <= (devState == 4'h4 && !preset) ? busyCnt + 8'h01 : 8'h00;
    if (preset) begin
      devState <= presetState;
    end else if (devState == 4'h4 && busyCnt == PROG_CYC) begin
      devState <= 4'h0;
    end else if (!flashOeN) begin
      lastQ <= {ready, 7'h00};
      polls <= polls + 2'h1;
      if (devState == 4'h5 && ready) devState <= 4'h6;
    end else if (!flashWeN) begin
      polls <= 2'h0;
      case (devState)
        4'h1: devState <= d == 8'h90 ? 4'h3 : d == 8'hA0 ? 4'h2 : d == 8'hF0 ? 4'h0 : 4'h1;
        4'h3: if (d == 8'h00 || d == 8'h03) devState <= 4'h0;
        4'h4: if (d == 8'hB0 || d == 8'h51) devState <= 4'h5;
        4'h6, 4'h8: if (d == 8'h30 || d == 8'h50) devState <= 4'h4;
          else if (d == 8'hAA && flashAddr == 12'h555) devState <= 4'h7;
        4'h7: if (d == 8'h55 && flashAddr == 12'h2AA) devState <= 4'h8;
        4'h9: if (d == 8'hF0 || (d == 8'h71 && flashAddr == 12'h555)) devState <= 4'h0;
        default: ;
      endcase
    end
  end
endmodule

// ### sim/suspend_cmd_host_asserts.sv
// assertions on the host sequencer ports
`timescale 1ns/1ps
module suspend_cmd_host_asserts (
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 opValid,
  input wire suspend_cmd_pkg::op_e opCode,
  input wire logic [7:0]           opArg,
  input wire logic                 opReady,
  input wire logic                 opDone,
  input wire logic [11:0]          flashAddr,
  input wire logic [7:0]           flashDout,
  input wire logic                 flashDoe,
  input wire logic                 flashWeN,
  input wire logic                 flashOeN
);
  import suspend_cmd_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // a request is taken on this edge
  wire tk = opValid && opReady;
  property p_drv; !flashWeN |-> flashDoe; endproperty
  a_drv: assert property (p_drv) else $error("data not driven");
  property p_dn; opDone |=> opReady && !opDone; endproperty
  a_dn: assert property (p_dn) else $error("done handshake");
  // first write strobe is registered one edge after the take, seen one edge later
  property p_st; tk && opCode == OP_STATUS |-> ##2 !flashWeN && flashAddr == ADDR_UNLOCK1
    && flashDout == CMD_STATUS ##1 !flashOeN; endproperty
  a_st: assert property (p_st) else $error("status entry");
  property p_bit; tk && opCode == OP_PROT_SET |-> ##2 !flashWeN && flashDout == CMD_BIT_WRITE;
  endproperty
  a_bit: assert property (p_bit) else $error("bit write code");
  property p_ex; tk && opCode == OP_PROT_EXIT |-> ##2 !flashWeN && flashDout == CMD_EXIT_ENTRY
    ##2 !flashWeN && flashDout == CMD_EXIT; endproperty
  a_ex: assert property (p_ex) else $error("exit pair");
  property p_ul; tk && opCode == OP_UNLOCK_RES |-> ##2 !flashWeN && flashAddr == ADDR_UNLOCK1
    && flashDout == CMD_UNLOCK1 ##2 !flashWeN && flashAddr == ADDR_UNLOCK2
    && flashDout == CMD_UNLOCK2 ##2 !flashWeN
    && flashDout == ($past(opArg[0], 6) ? CMD_PG_RESUME : CMD_RESUME); endproperty
  a_ul: assert property (p_ul) else $error("unlock order");
  property p_sus; tk && opCode == OP_SUSPEND |-> ##2 !flashWeN
    && flashDout == ($past(opArg[0], 2) ? CMD_PG_SUSPEND : CMD_SUSPEND); endproperty
  a_sus: assert property (p_sus) else $error("suspend code");
  property p_res; tk && opCode == OP_RESUME |-> ##2 !flashWeN
    && flashDout == ($past(opArg[0], 2) ? CMD_PG_RESUME : CMD_RESUME); endproperty
  a_res: assert property (p_res) else $error("resume code");
endmodule
bind suspend_cmd_host suspend_cmd_host_asserts chk (.mclk, .resetn, .opValid, .opCode,
  .opArg, .opReady, .opDone, .flashAddr, .flashDout, .flashDoe, .flashWeN, .flashOeN);

// ### sim/test_erase_suspend_command_fsm.sv
// self-checking bench for the host sequencer against a flash model
`timescale 1ns/1ps
module test_erase_suspend_command_fsm;
  import suspend_cmd_pkg::*;
  logic mclk = 0, resetn = 0, opValid = 0, preset = 0, opReady, opDone;
  logic flashDoe, flashWeN, flashOeN;
  op_e opCode = OP_STATUS;
  logic [7:0] opArg = 8'h00, statusOut, flashDout, flashDin;
  logic [11:0] flashAddr;
  logic [3:0] presetState = 4'h0, devState;
  int errors = 0, num_checks = 0, n;
  suspend_cmd_host uut (.mclk, .resetn, .opValid, .opCode, .opArg, .opReady, .opDone,
    .statusOut, .flashAddr, .flashDout, .flashDoe, .flashWeN, .flashOeN, .flashDin);
  flash_model dev (.mclk, .flashAddr, .flashDout, .flashWeN, .flashOeN, .preset,
    .presetState, .flashDin, .devState);
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one request, held until an edge that samples opReady high, then wait for done
  task do_op(op_e o, logic [7:0] a, logic [3:0] s);
    @(posedge mclk) preset <= 0;
    opValid <= 1;
    opCode <= o;
    opArg <= a;
    do @(posedge mclk); while (opReady !== 1'b1);
    opValid <= 0;
    n = 0;
    while (opDone !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("opDone", 8'h01, {7'h00, opDone});
    chk("devState", {4'h0, s}, {4'h0, devState});
  endtask
  task set_dev(logic [3:0] s);
    @(posedge mclk) preset <= 1;
    presetState <= s;
  endtask
  task t_prot;
    set_dev(4'h1);
    do_op(OP_PROT_SET, 8'h00, 4'h2);
    set_dev(4'h1);
    do_op(OP_PROT_EXIT, 8'h00, 4'h0);
  endtask
  task t_susp(logic [7:0] a);
    set_dev(4'h4);
    do_op(OP_SUSPEND, a, 4'h6);
    chk("statusOut", 8'h80, statusOut);
  endtask
  task t_resume(op_e o, logic [7:0] a);
    set_dev(4'h6);
    do_op(o, a, 4'h4);
  endtask
  // programming left alone finishes; the status read then shows ready
  task t_idle;
    set_dev(4'h4);
    @(posedge mclk) preset <= 0;
    repeat (205) @(posedge mclk);
    do_op(OP_STATUS, 8'h00, 4'h0);
    chk("statusOut", 8'h80, statusOut);
  endtask
  // busy status, an ignored code, then both exits
  task t_exit;
    set_dev(4'h4);
    do_op(OP_STATUS, 8'h00, 4'h4);
    chk("statusOut", 8'h00, statusOut);
    do_op(OP_PROT_SET, 8'h00, 4'h4);
    set_dev(4'h9);
    do_op(OP_STAT_CLR, 8'h00, 4'h0);
    set_dev(4'h1);
    do_op(OP_RESET, 8'h00, 4'h0);
    chk("latency", 8'h01, {7'h00, n > LATENCY_CYC});
  endtask
  // free-running clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1;
    t_prot;
    t_susp(8'h00);
    t_susp(8'h01);
    t_resume(OP_RESUME, 8'h00);
    t_resume(OP_RESUME, 8'h01);
    t_resume(OP_UNLOCK_RES, 8'h00);
    t_resume(OP_UNLOCK_RES, 8'h01);
    t_exit;
    t_idle;
    summarize;
  end
  // watchdog well past the reset latency wait
  initial begin
    #500000;
    errors++;
    summarize;
  end
  task summarize;
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule
